// file: tasp_pkg.sv
// constants and types for the touch converter serial port
package tasp_pkg;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 5;
  // falling-edge counts (rising-edge for CMD_DONE) within one 24-clock conversion frame
  localparam logic [4:0] BUSY_EDGE = 5'h08;
  localparam logic [4:0] MSB_EDGE = 5'h09;
  localparam logic [4:0] LAST_EDGE = 5'h14;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] CMD_DONE = 5'h08;
  // command fields
  localparam int unsigned CMD_CH_MSB = 6;
  localparam int unsigned CMD_CH_LSB = 4;
  localparam int unsigned CMD_PD_MSB = 1;
  localparam int unsigned CMD_PD_LSB = 0;
  localparam logic [1:0] PD_BETWEEN = 2'h0;
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_X = 3'h1;
  localparam logic [2:0] CH_BAT = 3'h2;
  localparam logic [2:0] CH_Z1 = 3'h3;
  localparam logic [2:0] CH_Z2 = 3'h4;
  localparam logic [2:0] CH_Y = 3'h5;
  // plate bit positions
  localparam int unsigned X_PLUS_PLATE = 0;
  localparam int unsigned Y_PLUS_PLATE = 1;
  localparam int unsigned X_MINUS_PLATE = 2;
  localparam int unsigned Y_MINUS_PLATE = 3;
  localparam logic [3:0] PLATE_NONE = 4'h0;
  localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  typedef enum logic [2:0] {
    TASP_PDN,
    TASP_XM,
    TASP_YM,
    TASP_Z1M,
    TASP_Z2M,
    TASP_AUXM
  } tasp_mode_e;
endpackage

// file: tasp_serial_port.sv
// serial command/result port, result fifo and plate switch control
// What this block does
// - command bits sampled on serial clock rise
// - result bits change on serial clock fall
// - result msb appears as busy falls
// - data output low when no bit shown
// - select high floats data and busy
// - select low drives busy low
// - busy high from fall eight to nine
// - command word written only while selected
// - x mode: drive x plates, sense y+
// - y mode: drive y plates, sense x+
// - pressure: drive y+ x-, sense x+/y-
// - powerdown: y- grounded, x+ pulled up
`timescale 1ns/1ps

module tasp_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];
  assign out_valid = (count_ff != '0);

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= nxt_count;
      // registered so the port comes straight from a flop
      in_ready <= (nxt_count < (AW+1)'(DEPTH));
    end
  end
endmodule // tasp_fifo

module tasp_serial_port (
  // system side
  input wire logic sys_clk,
  input wire logic rst_n,
  // converter results into the fifo
  input wire logic [tasp_pkg::RES_W-1:0] conv_result,
  input wire logic conv_valid,
  output logic conv_ready,
  // decoded command to the converter
  output logic [tasp_pkg::CMD_W-1:0] conv_cmd_ff,
  output logic conv_cmd_strobe_ff,
  // serial pins
  input wire logic serial_shift_clock,
  input wire logic chip_sel_n,
  input wire logic serial_cmd_in,
  output logic serial_data_out_ff,
  output logic serial_data_oe_ff,
  output logic busy_out_ff,
  output logic busy_oe_ff,
  // plate switches
  output logic [3:0] plate_drive_ff,
  output logic [3:0] plate_to_adc_ff,
  output logic x_plus_plate_pull_up_ff
);
  localparam logic [4:0] CNT_ONE = 5'h01;

  // link domain
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic [4:0] rise_cnt_ff;
  logic [4:0] nxt_rise_cnt;
  logic [tasp_pkg::CMD_W-1:0] cmd_sh_ff;
  logic [tasp_pkg::CMD_W-1:0] cmd_word_ff;
  logic cmd_tog_ff;
  logic load_s1_ff;
  logic load_s2_ff;
  logic [4:0] fall_cnt_ff;
  logic [4:0] nxt_fall_cnt;
  logic [tasp_pkg::RES_W-1:0] res_sh_ff;
  logic taken_tog_ff;
  logic res_msb;
  // system domain
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cmd_s1_ff;
  logic cmd_s2_ff;
  logic cmd_s3_ff;
  logic taken_s1_ff;
  logic taken_s2_ff;
  logic [tasp_pkg::RES_W-1:0] hold_ff;
  logic load_tog_ff;
  logic hold_free;
  logic [tasp_pkg::RES_W-1:0] fifo_data;
  logic fifo_valid;
  tasp_pkg::tasp_mode_e mode_ff;
  logic pdn_after_ff;

  tasp_fifo #(
    .WIDTH(tasp_pkg::RES_W),
    .DEPTH(tasp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(conv_result),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(hold_free)
  );

  // ---------------- link domain ----------------
  // the link clock only runs in frames; reset needs a few edges to land
  always_ff @(posedge serial_shift_clock) begin
    lrst_s1_ff <= rst_n;
    lrst_s2_ff <= lrst_s1_ff;
  end

  assign nxt_rise_cnt = (rise_cnt_ff == tasp_pkg::FRAME_LAST) ? 5'h00 : rise_cnt_ff + CNT_ONE;
  assign nxt_fall_cnt = (fall_cnt_ff == tasp_pkg::FRAME_LAST) ? 5'h00 : fall_cnt_ff + CNT_ONE;
  assign res_msb = res_sh_ff[tasp_pkg::RES_W-1];

  // frame state ends with the select pin itself
  always_ff @(posedge serial_shift_clock or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      rise_cnt_ff <= 5'h00;
      cmd_sh_ff <= tasp_pkg::CMD_RST;
    end else begin
      rise_cnt_ff <= nxt_rise_cnt;
      cmd_sh_ff <= {cmd_sh_ff[tasp_pkg::CMD_W-2:0], serial_cmd_in};
    end
  end

  always_ff @(posedge serial_shift_clock) begin
    if (!lrst_s2_ff) begin
      cmd_word_ff <= tasp_pkg::CMD_RST;
      cmd_tog_ff <= 1'b0;
      load_s1_ff <= 1'b0;
      load_s2_ff <= 1'b0;
    end else begin
      load_s1_ff <= load_tog_ff;
      load_s2_ff <= load_s1_ff;
      // counter is held clear while deselected, so no write then
      if (!chip_sel_n && nxt_rise_cnt == tasp_pkg::CMD_DONE) begin
        cmd_word_ff <= {cmd_sh_ff[tasp_pkg::CMD_W-2:0], serial_cmd_in};
        cmd_tog_ff <= !cmd_tog_ff;
      end
    end
  end

  always_ff @(negedge serial_shift_clock or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      fall_cnt_ff <= 5'h00;
      busy_out_ff <= 1'b0;
      serial_data_out_ff <= 1'b0;
      res_sh_ff <= tasp_pkg::RES_RST;
    end else begin
      fall_cnt_ff <= nxt_fall_cnt;
      busy_out_ff <= (nxt_fall_cnt == tasp_pkg::BUSY_EDGE);
      if (nxt_fall_cnt == tasp_pkg::BUSY_EDGE) begin
        // no fresh word ready: shift out zeros rather than stall
        res_sh_ff <= (load_s2_ff != taken_tog_ff) ? hold_ff : tasp_pkg::RES_RST;
        serial_data_out_ff <= 1'b0;
      end else if (nxt_fall_cnt >= tasp_pkg::MSB_EDGE && nxt_fall_cnt <= tasp_pkg::LAST_EDGE) begin
        serial_data_out_ff <= res_msb;
        res_sh_ff <= {res_sh_ff[tasp_pkg::RES_W-2:0], 1'b0};
      end else begin
        serial_data_out_ff <= 1'b0;
      end
    end
  end

  always_ff @(negedge serial_shift_clock) begin
    if (!lrst_s2_ff) begin
      taken_tog_ff <= 1'b0;
    end else if (!chip_sel_n && nxt_fall_cnt == tasp_pkg::BUSY_EDGE &&
                 load_s2_ff != taken_tog_ff) begin
      taken_tog_ff <= !taken_tog_ff;
    end
  end

  // ---------------- system domain ----------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cmd_s1_ff <= 1'b0;
      cmd_s2_ff <= 1'b0;
      cmd_s3_ff <= 1'b0;
      taken_s1_ff <= 1'b0;
      taken_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff <= chip_sel_n;
      cs_s2_ff <= cs_s1_ff;
      cmd_s1_ff <= cmd_tog_ff;
      cmd_s2_ff <= cmd_s1_ff;
      cmd_s3_ff <= cmd_s2_ff;
      taken_s1_ff <= taken_tog_ff;
      taken_s2_ff <= taken_s1_ff;
    end
  end

  // outputs float while deselected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_data_oe_ff <= 1'b0;
      busy_oe_ff <= 1'b0;
    end else begin
      serial_data_oe_ff <= !cs_s2_ff;
      busy_oe_ff <= !cs_s2_ff;
    end
  end

  // hold register only reloads once the link has taken its word,
  // so the link may read it without a multi-bit race
  assign hold_free = (taken_s2_ff == load_tog_ff);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_ff <= tasp_pkg::RES_RST;
      load_tog_ff <= 1'b0;
    end else if (hold_free && fifo_valid) begin
      hold_ff <= fifo_data;
      load_tog_ff <= !load_tog_ff;
    end
  end

  // command word is stable for the whole frame once its toggle arrives
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conv_cmd_ff <= tasp_pkg::CMD_RST;
      conv_cmd_strobe_ff <= 1'b0;
      mode_ff <= tasp_pkg::TASP_PDN;
      pdn_after_ff <= 1'b1;
    end else begin
      conv_cmd_strobe_ff <= (cmd_s2_ff != cmd_s3_ff);
      if (cmd_s2_ff != cmd_s3_ff) begin
        conv_cmd_ff <= cmd_word_ff;
        mode_ff <= chan_mode(cmd_word_ff[tasp_pkg::CMD_CH_MSB:tasp_pkg::CMD_CH_LSB]);
        pdn_after_ff <= (cmd_word_ff[tasp_pkg::CMD_PD_MSB:tasp_pkg::CMD_PD_LSB] ==
                         tasp_pkg::PD_BETWEEN);
      end else if (cs_s2_ff && pdn_after_ff) begin
        mode_ff <= tasp_pkg::TASP_PDN;
      end
    end
  end

  function automatic tasp_pkg::tasp_mode_e chan_mode(input logic [2:0] ch);
    tasp_pkg::tasp_mode_e m;
    m = tasp_pkg::TASP_AUXM;
    if (ch == tasp_pkg::CH_X) begin
      m = tasp_pkg::TASP_XM;
    end else if (ch == tasp_pkg::CH_Y) begin
      m = tasp_pkg::TASP_YM;
    end else if (ch == tasp_pkg::CH_Z1) begin
      m = tasp_pkg::TASP_Z1M;
    end else if (ch == tasp_pkg::CH_Z2) begin
      m = tasp_pkg::TASP_Z2M;
    end
    return m;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      plate_drive_ff <= tasp_pkg::PLATE_NONE;
      plate_to_adc_ff <= tasp_pkg::PLATE_NONE;
      x_plus_plate_pull_up_ff <= 1'b0;
    end else begin
      plate_drive_ff <= tasp_pkg::PLATE_NONE;
      plate_to_adc_ff <= tasp_pkg::PLATE_NONE;
      x_plus_plate_pull_up_ff <= 1'b0;
      case (mode_ff)
        tasp_pkg::TASP_XM: begin
          plate_drive_ff[tasp_pkg::X_PLUS_PLATE] <= 1'b1;
          plate_drive_ff[tasp_pkg::X_MINUS_PLATE] <= 1'b1;
          plate_to_adc_ff[tasp_pkg::Y_PLUS_PLATE] <= 1'b1;
        end
        tasp_pkg::TASP_YM: begin
          plate_drive_ff[tasp_pkg::Y_PLUS_PLATE] <= 1'b1;
          plate_drive_ff[tasp_pkg::Y_MINUS_PLATE] <= 1'b1;
          plate_to_adc_ff[tasp_pkg::X_PLUS_PLATE] <= 1'b1;
        end
        tasp_pkg::TASP_Z1M: begin
          plate_drive_ff[tasp_pkg::Y_PLUS_PLATE] <= 1'b1;
          plate_drive_ff[tasp_pkg::X_MINUS_PLATE] <= 1'b1;
          plate_to_adc_ff[tasp_pkg::X_PLUS_PLATE] <= 1'b1;
        end
        tasp_pkg::TASP_Z2M: begin
          plate_drive_ff[tasp_pkg::Y_PLUS_PLATE] <= 1'b1;
          plate_drive_ff[tasp_pkg::X_MINUS_PLATE] <= 1'b1;
          plate_to_adc_ff[tasp_pkg::Y_MINUS_PLATE] <= 1'b1;
        end
        tasp_pkg::TASP_PDN: begin
          plate_drive_ff[tasp_pkg::Y_MINUS_PLATE] <= 1'b1;
          x_plus_plate_pull_up_ff <= 1'b1;
        end
        default: begin
          plate_drive_ff <= tasp_pkg::PLATE_NONE;
        end
      endcase
    end
  end

  // ---------------- checks ----------------
  busy_window_a: assert property (@(negedge serial_shift_clock) disable iff (chip_sel_n)
    busy_out_ff |-> fall_cnt_ff == 5'h08 ##1 !busy_out_ff)
    else $error("busy outside fall eight to nine");
  busy_needs_a: assert property (@(negedge serial_shift_clock) disable iff (chip_sel_n)
    fall_cnt_ff == 5'h08 |-> busy_out_ff)
    else $error("busy missing after eighth fall");
  msb_at_fall_a: assert property (@(negedge serial_shift_clock) disable iff (chip_sel_n)
    $fell(busy_out_ff) |-> serial_data_out_ff == $past(res_msb))
    else $error("msb not shown as busy falls");
  result_bits_a: assert property (@(negedge serial_shift_clock) disable iff (chip_sel_n)
    (fall_cnt_ff >= 5'h0a && fall_cnt_ff <= 5'h14) |-> serial_data_out_ff == $past(res_msb))
    else $error("result bit out of order");
  idle_low_a: assert property (@(negedge serial_shift_clock) disable iff (chip_sel_n)
    (fall_cnt_ff < 5'h09 || fall_cnt_ff > 5'h14) |-> !serial_data_out_ff)
    else $error("data output not low when idle");
  cmd_capture_a: assert property (@(posedge serial_shift_clock) disable iff (!lrst_s2_ff)
    (!chip_sel_n && rise_cnt_ff == 5'h07) |=> cmd_word_ff[0] == $past(serial_cmd_in))
    else $error("command bit not taken on rise");
  float_desel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_s2_ff [*2] |-> !serial_data_oe_ff && !busy_oe_ff)
    else $error("outputs driven while deselected");
  x_plates_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_ff == tasp_pkg::TASP_XM |=> plate_drive_ff == 4'h5 && plate_to_adc_ff == 4'h2)
    else $error("x measurement plates wrong");
  pdown_plates_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_ff == tasp_pkg::TASP_PDN |=> plate_drive_ff == 4'h8 && x_plus_plate_pull_up_ff)
    else $error("powerdown plates wrong");
  z2_plates_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_ff == tasp_pkg::TASP_Z2M |=> plate_drive_ff == 4'h6 && plate_to_adc_ff == 4'h8)
    else $error("second pressure plates wrong");
endmodule // tasp_serial_port

// file: tasp_host_model.sv
// host model: frames the serial port and gathers its answers
`timescale 1ns/1ps

module tasp_host_model (
  // driven pins
  output logic serial_shift_clock,
  output logic chip_sel_n,
  output logic serial_cmd_in,
  // resolved device pins
  input wire logic data_pin,
  input wire logic busy_pin
);
  logic [11:0] res;
  logic [2:0] busy_seen;
  logic idle_or;

  initial begin
    serial_shift_clock = 1'b0;
    chip_sel_n = 1'b1;
    serial_cmd_in = 1'b0;
  end

  // one 32 ns period; the pins are sampled 8 ns after the fall
  task automatic tick(input logic bit_in);
    serial_cmd_in = bit_in;
    #8 serial_shift_clock = 1'b1;
    #16 serial_shift_clock = 1'b0;
    #8;
  endtask

  // clock runs only while selected; gaps let the enables settle
  task automatic frame(input logic [7:0] cmd);
    chip_sel_n = 1'b0;
    idle_or = 1'b0;
    #500;
    for (int i = 1; i <= 24; i++) begin
      tick(i <= 8 ? cmd[8-i] : 1'b0);
      if (i >= 7 && i <= 9) busy_seen[9-i] = busy_pin;
      if (i >= 9 && i <= 20) res = {res[10:0], data_pin};
      else idle_or = idle_or | data_pin;
    end
    serial_cmd_in = 1'b0;
    chip_sel_n = 1'b1;
    #500;
  endtask

  // stray clocks with select high, at reset or on purpose
  task automatic idle_clk(input logic [7:0] cmd);
    for (int i = 7; i >= 0; i--) tick(cmd[i]);
    serial_cmd_in = 1'b0;
  endtask
endmodule // tasp_host_model

// file: testbench.sv
// self-checking bench for the touch converter serial port
`timescale 1ns/1ps

module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [tasp_pkg::RES_W-1:0] conv_result = 12'h000;
  logic conv_valid = 1'b0;
  logic conv_ready;
  logic [tasp_pkg::CMD_W-1:0] conv_cmd_ff;
  logic conv_cmd_strobe_ff;
  logic serial_shift_clock;
  logic chip_sel_n;
  logic serial_cmd_in;
  logic serial_data_out_ff;
  logic serial_data_oe_ff;
  logic busy_out_ff;
  logic busy_oe_ff;
  logic [3:0] plate_drive_ff;
  logic [3:0] plate_to_adc_ff;
  logic x_plus_plate_pull_up_ff;
  int err_count = 0;
  int cmp_count = 0;
  int strobes = 0;
  int cycles = 0;
  // no pull on either pin, so a float shows as z
  wire data_pin = serial_data_oe_ff ? serial_data_out_ff : 1'bz;
  wire busy_pin = busy_oe_ff ? busy_out_ff : 1'bz;

  always #50 sys_clk = ~sys_clk;

  tasp_serial_port dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .conv_result(conv_result),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_cmd_ff(conv_cmd_ff),
    .conv_cmd_strobe_ff(conv_cmd_strobe_ff), .serial_shift_clock(serial_shift_clock),
    .chip_sel_n(chip_sel_n), .serial_cmd_in(serial_cmd_in),
    .serial_data_out_ff(serial_data_out_ff), .serial_data_oe_ff(serial_data_oe_ff),
    .busy_out_ff(busy_out_ff), .busy_oe_ff(busy_oe_ff), .plate_drive_ff(plate_drive_ff),
    .plate_to_adc_ff(plate_to_adc_ff), .x_plus_plate_pull_up_ff(x_plus_plate_pull_up_ff)
  );

  tasp_host_model host (
    .serial_shift_clock(serial_shift_clock), .chip_sel_n(chip_sel_n),
    .serial_cmd_in(serial_cmd_in), .data_pin(data_pin), .busy_pin(busy_pin)
  );

  task automatic summarize();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // about 30 frames of some 18 cycles each, so 2000 is ample
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (conv_cmd_strobe_ff === 1'b1) strobes <= strobes + 1;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [11:0] plates();
    return {3'h0, x_plus_plate_pull_up_ff, plate_drive_ff, plate_to_adc_ff};
  endfunction

  // offers words base, base+1, ...; each stays valid until it is taken
  task automatic push(input logic [11:0] base, input int n);
    @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      conv_valid <= 1'b1;
      conv_result <= base + 12'(i);
      // ready only moves on the rise, so the fall shows what the rise sees
      @(negedge sys_clk);
      while (conv_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    conv_valid <= 1'b0;
  endtask

  task automatic t_reset();
    // link reset needs clocks while system reset is still held
    fork
      host.idle_clk(8'h00);
      repeat (4) @(posedge sys_clk);
    join
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("plates", plates(), 12'h180);
    check("enables", {10'h0, serial_data_oe_ff, busy_oe_ff}, 12'h000);
  endtask

  task automatic t_xmode();
    int s0;
    push(12'ha5c, 1);
    repeat (4) @(posedge sys_clk);
    s0 = strobes;
    host.frame({1'b1, tasp_pkg::CH_X, 4'h3});
    @(negedge sys_clk);
    check("result", host.res, 12'ha5c);
    check("busy", {9'h0, host.busy_seen}, 12'h002);
    check("idle_data", {11'h0, host.idle_or}, 12'h000);
    check("enables", {10'h0, serial_data_oe_ff, busy_oe_ff}, 12'h000);
    check("command", {4'h0, conv_cmd_ff}, 12'h093);
    check("strobes", 12'(strobes - s0), 12'h001);
    check("plates", plates(), 12'h052);
  endtask

  // channel, then expected drive and converter routing
  task automatic t_modes();
    logic [10:0] tab [7] = '{11'h5a1, 11'h361, 11'h468, 11'h000, 11'h200, 11'h600, 11'h700};
    for (int i = 0; i < 7; i++) begin
      host.frame({1'b1, tab[i][10:8], 4'h3});
      @(negedge sys_clk);
      check("stale_result", host.res, 12'h000);
      check("plates", plates(), {4'h0, tab[i][7:0]});
    end
  endtask

  // hold register plus sixteen fifo words fill up, then drain in order
  task automatic t_fifo();
    push(12'h100, 17);
    @(negedge sys_clk);
    check("fill", {11'h0, conv_ready}, 12'h000);
    for (int i = 0; i < 17; i++) begin
      host.frame({1'b1, tasp_pkg::CH_X, 4'h3});
      check("drain", host.res, 12'h100 + 12'(i));
    end
    host.frame({1'b1, tasp_pkg::CH_X, 4'h3});
    @(negedge sys_clk);
    check("empty", host.res, 12'h000);
    check("ready", {11'h0, conv_ready}, 12'h001);
  endtask

  task automatic t_desel();
    int s0;
    s0 = strobes;
    host.idle_clk(8'hd3);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check("command", {4'h0, conv_cmd_ff}, 12'h093);
    check("strobes", 12'(strobes - s0), 12'h000);
    host.frame({1'b1, tasp_pkg::CH_Y, 4'h0});
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("powerdown", plates(), 12'h180);
  endtask

  initial begin
    t_reset();
    t_xmode();
    t_modes();
    t_fifo();
    t_desel();
    summarize();
  end
endmodule // testbench
